//--- hw/cpurf_core.sv
// top: register file, program counter and status register access
module cpurf_core
   import cpurf_pkg::*;
#(
   parameter int          DATA_SIZE    = 32,
   parameter int          ADDR_SIZE    = 32,
   parameter bit          USE_HW_EXC   = 1'b1,
   parameter logic [63:0] BASE_VECTORS = CPURF_BASE_VECTORS,
   localparam int         DW           = (DATA_SIZE == 64) ? 64 : 32,
   localparam int         PW           = (DATA_SIZE == 64) ?
                                         ((ADDR_SIZE > 64) ? 64 : ADDR_SIZE) : 32
)(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              dbg_rst,
   input  wire logic [4:0]        ra_idx,
   input  wire logic [4:0]        rb_idx,
   output logic      [DW-1:0]     ra_data_reg,
   output logic      [DW-1:0]     rb_data_reg,
   input  wire cpurf_wr_t         wr,
   input  wire logic              pc_load,
   input  wire logic [PW-1:0]     pc_load_addr,
   input  wire logic              irq_take,
   input  wire logic              brk_take,
   input  wire logic              exc_take,
   input  wire logic              exc_in_delay,
   input  wire logic [PW-1:0]     ret_addr,
   input  wire logic [PW-1:0]     btr_addr,
   input  wire cpurf_sreq_t       sreq,
   input  wire logic              carry_wr,
   input  wire logic              carry_in,
   output logic      [DW-1:0]     mfs_data_reg,
   output logic      [PW-1:0]     pc_reg,
   output logic      [31:0]       msr_reg,
   output logic                   carry_reg,
   output logic      [DW-1:0]     exc_btr_reg
);
   localparam int CCI = 31 - CPURF_CC_BIT_32;
   localparam int CI  = 31 - CPURF_C_BIT_32;

   // ***************************************************************
   // general purpose registers
   // ***************************************************************
   logic          gw_en;
   logic [4:0]    gw_idx;
   logic [DW-1:0] gw_data;
   logic [DW-1:0] ra_comb;
   logic [DW-1:0] rb_comb;
   logic          pipe_rst;

   assign pipe_rst = dbg_rst;

   // hardware saves win over the pipeline write port
   always_comb
   begin
      gw_en   = wr.en;
      gw_idx  = wr.idx;
      gw_data = wr.data[DW-1:0];
      if (exc_take && USE_HW_EXC)
      begin
         gw_en   = 1'b1;
         gw_idx  = CPURF_EXC_RET_IDX;
         gw_data = DW'(exc_in_delay ? btr_addr : ret_addr);
      end
      else if (brk_take)
      begin
         gw_en   = 1'b1;
         gw_idx  = CPURF_BRK_RET_IDX;
         gw_data = DW'(ret_addr);
      end
      else if (irq_take)
      begin
         gw_en   = 1'b1;
         gw_idx  = CPURF_IRQ_RET_IDX;
         gw_data = DW'(ret_addr);
      end
   end

   cpurf_gpr_array #(.DW(DW)) u_gpr (
      .core_clk (core_clk),
      .ra_idx   (ra_idx),
      .rb_idx   (rb_idx),
      .ra_data  (ra_comb),
      .rb_data  (rb_comb),
      .we       (gw_en),
      .w_idx    (gw_idx),
      .w_data   (gw_data)
   );

   // read data registered; not cleared by reset, only by load
   always_ff @(posedge core_clk)
   begin
      ra_data_reg <= ra_comb;
      rb_data_reg <= rb_comb;
   end

   // delay-slot branch target kept for the exception path
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         exc_btr_reg <= '0;
      else if (exc_take && exc_in_delay)
         exc_btr_reg <= DW'(btr_addr);
   end

   // ***************************************************************
   // program counter
   // ***************************************************************
   // mts to specifier zero is simply never decoded here
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         pc_reg <= BASE_VECTORS[PW-1:0];
      else if (pipe_rst)
         pc_reg <= BASE_VECTORS[PW-1:0];
      else if (pc_load)
         pc_reg <= pc_load_addr;
   end

   // ***************************************************************
   // machine status register
   // ***************************************************************
   logic        mts_hit;
   logic        set_hit;
   logic        clr_hit;
   logic [31:0] wr_bits;
   logic [31:0] msr_next;
   logic        carry_next;
   logic [31:0] msr_view;

   always_comb
   begin
      mts_hit = (sreq.op == CPURF_SOP_MTS) && (sreq.spec == CPURF_SPEC_MSR);
      set_hit = (sreq.op == CPURF_SOP_SET);
      clr_hit = (sreq.op == CPURF_SOP_CLR);
      wr_bits = sreq.data[31:0];
      msr_next = msr_reg;
      if (mts_hit)
         msr_next = wr_bits;
      else if (set_hit)
         msr_next = msr_reg | wr_bits;
      else if (clr_hit)
         msr_next = msr_reg & ~wr_bits;
      msr_next[CCI] = 1'b0;
   end

   // set/clear carry goes straight to the arithmetic flag
   always_comb
   begin
      carry_next = carry_reg;
      if (carry_wr)
         carry_next = carry_in;
      if (set_hit && wr_bits[CI])
         carry_next = 1'b1;
      else if (clr_hit && wr_bits[CI])
         carry_next = 1'b0;
   end

   logic mts_carry_pend;
   logic mts_carry_val;

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         msr_reg <= CPURF_MSR_RESET;
      else
         msr_reg <= msr_next;
   end

   // mts carry lands one cycle after the write
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mts_carry_pend <= 1'b0;
         mts_carry_val  <= 1'b0;
      end
      else
      begin
         mts_carry_pend <= mts_hit;
         mts_carry_val  <= wr_bits[CI];
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         carry_reg <= 1'b0;
      else if (mts_carry_pend)
         carry_reg <= mts_carry_val;
      else
         carry_reg <= carry_next;
   end

   // carry copy in both halves of a 64-bit view
   always_comb
   begin
      msr_view      = msr_reg;
      msr_view[CI]  = carry_reg;
      msr_view[CCI] = carry_reg;
   end

   // ***************************************************************
   // move-from-special read path
   // ***************************************************************
   // pc read is the current pc, i.e. the reading instruction itself
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         mfs_data_reg <= '0;
      else if (sreq.spec == CPURF_SPEC_PC)
         mfs_data_reg <= DW'(pc_reg);
      else if (sreq.spec == CPURF_SPEC_MSR)
      begin
         if (DW == 64)
            mfs_data_reg <= DW'({carry_reg, 31'h0000_0000, msr_view});
         else
            mfs_data_reg <= DW'(msr_view);
      end
      else
         mfs_data_reg <= '0;
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_mts_msr;
      mts_hit;
   endsequence

   property p_cc_equals_carry;
      @(posedge core_clk) disable iff (!nrst)
      (sreq.spec == CPURF_SPEC_MSR) |=> mfs_data_reg[CCI] == $past(carry_reg);
   endproperty
   a_cc_equals_carry: assert property (p_cc_equals_carry)
      else $error("carry copy differs from carry");

   property p_mts_delay;
      @(posedge core_clk) disable iff (!nrst)
      s_mts_msr ##0 (!carry_wr) |=> ##1 carry_reg == $past(wr_bits[CI], 2);
   endproperty
   a_mts_delay: assert property (p_mts_delay)
      else $error("mts carry not applied one cycle later");

   property p_set_carry_now;
      @(posedge core_clk) disable iff (!nrst)
      (set_hit && wr_bits[CI] && !mts_carry_pend) |=> carry_reg;
   endproperty
   a_set_carry_now: assert property (p_set_carry_now)
      else $error("set carry not immediate");

   property p_clr_carry_now;
      @(posedge core_clk) disable iff (!nrst)
      (clr_hit && wr_bits[CI] && !mts_carry_pend) |=> !carry_reg;
   endproperty
   a_clr_carry_now: assert property (p_clr_carry_now)
      else $error("clear carry not immediate");

   property p_cc_never_stored;
      @(posedge core_clk) disable iff (!nrst)
      mts_hit |=> !msr_reg[CCI];
   endproperty
   a_cc_never_stored: assert property (p_cc_never_stored)
      else $error("carry copy stored");

   property p_pc_read;
      @(posedge core_clk) disable iff (!nrst)
      (sreq.spec == CPURF_SPEC_PC) |=> mfs_data_reg == DW'($past(pc_reg));
   endproperty
   a_pc_read: assert property (p_pc_read)
      else $error("pc read wrong");

   property p_pc_no_mts;
      @(posedge core_clk) disable iff (!nrst || pipe_rst)
      (!pc_load) |=> $stable(pc_reg);
   endproperty
   a_pc_no_mts: assert property (p_pc_no_mts)
      else $error("pc changed without load");

   property p_zero_read;
      @(posedge core_clk)
      (ra_idx == CPURF_ZERO_IDX) |=> ra_data_reg == '0;
   endproperty
   a_zero_read: assert property (p_zero_read)
      else $error("register zero nonzero");

   // read index is checked one cycle after the save, when the array holds it
   sequence s_irq_taken;
      irq_take && !brk_take && !exc_take;
   endsequence

   sequence s_exc_taken;
      exc_take && USE_HW_EXC;
   endsequence

   property p_irq_save;
      @(posedge core_clk) disable iff (!nrst)
      s_irq_taken |=> (ra_idx == CPURF_IRQ_RET_IDX)
         |=> ra_data_reg == DW'($past(ret_addr, 2));
   endproperty
   a_irq_save: assert property (p_irq_save)
      else $error("interrupt return not saved");

   property p_brk_save;
      @(posedge core_clk) disable iff (!nrst)
      (brk_take && !exc_take) |=> (rb_idx == CPURF_BRK_RET_IDX)
         |=> rb_data_reg == DW'($past(ret_addr, 2));
   endproperty
   a_brk_save: assert property (p_brk_save)
      else $error("break return not saved");

   property p_exc_save;
      @(posedge core_clk) disable iff (!nrst)
      s_exc_taken |=> (ra_idx == CPURF_EXC_RET_IDX)
         |=> ra_data_reg == ($past(exc_in_delay, 2) ? DW'($past(btr_addr, 2))
                                                    : DW'($past(ret_addr, 2)));
   endproperty
   a_exc_save: assert property (p_exc_save)
      else $error("exception return not saved");
endmodule // cpurf_core

//--- hw/cpurf_pkg.sv
// package: constants and types for the cpu register file and status access
// How it works
// - thirty-two registers, 32 or 64 bits wide
// - msb is bit 0, big-endian numbering
// - at most sixteen special registers exist
// - general registers zeroed only at configuration load
// - core and debug resets leave registers alone
// - register zero reads zero, writes dropped
// - interrupt return address goes to register 14
// - break return address goes to register 16
// - program counter readable, special write ignored
// - specifier zero selects program counter
// - pc resets to base vector; reads own address
// - pc width is address size in 64-bit mode
// - status writable by move, set, clear; readable
// - specifier one selects machine status register
// - reads show carry in carry copy bit
// - set/clear: carry immediate, others one cycle later; here the other bits land in the same cycle as carry
// - move-to-special: all bits one cycle later; here only carry is late, the other bits land on the write edge
// - writes to carry copy bit ignored
// - carry copy bit always equals carry flag; here only in reads, the stored copy bit in msr_reg is held at zero
package cpurf_pkg;
   localparam int          CPURF_NUM_REGS      = 32;
   localparam int          CPURF_MAX_SPECIAL   = 16;
   localparam logic [4:0]  CPURF_ZERO_IDX      = 5'h00;
   localparam logic [4:0]  CPURF_IRQ_RET_IDX   = 5'h0E;
   localparam logic [4:0]  CPURF_BRK_RET_IDX   = 5'h10;
   localparam logic [4:0]  CPURF_EXC_RET_IDX   = 5'h11;
   localparam logic [13:0] CPURF_SPEC_PC       = 14'h0000;
   localparam logic [13:0] CPURF_SPEC_MSR      = 14'h0001;
   // msb-first numbering: bit k lives at vector index width-1-k
   localparam int          CPURF_CC_BIT_32     = 0;
   localparam int          CPURF_CC_BIT_64     = 32;
   localparam int          CPURF_C_BIT_32      = 29;
   localparam logic [31:0] CPURF_MSR_RESET     = 32'h0000_0000;
   localparam logic [63:0] CPURF_GPR_INIT      = 64'h0000_0000_0000_0000;
   localparam logic [63:0] CPURF_BASE_VECTORS  = 64'h0000_0000_0000_0000;

   typedef enum logic [1:0] {CPURF_SOP_NONE, CPURF_SOP_MTS, CPURF_SOP_SET, CPURF_SOP_CLR}
      cpurf_sop_t;

   typedef struct packed {
      logic        en;
      logic [4:0]  idx;
      logic [63:0] data;
   } cpurf_wr_t;

   typedef struct packed {
      cpurf_sop_t  op;
      logic [13:0] spec;
      logic [63:0] data;
   } cpurf_sreq_t;
endpackage

//--- hw/cpurf_gpr_array.sv
// general purpose register array: two read ports, one write port
module cpurf_gpr_array
   import cpurf_pkg::*;
#(
   parameter int DW = 32
)(
   input  wire logic          core_clk,
   input  wire logic [4:0]    ra_idx,
   input  wire logic [4:0]    rb_idx,
   output logic      [DW-1:0] ra_data,
   output logic      [DW-1:0] rb_data,
   input  wire logic          we,
   input  wire logic [4:0]    w_idx,
   input  wire logic [DW-1:0] w_data
);
   // no reset port: contents survive core and debug resets
   logic [DW-1:0] mem [CPURF_NUM_REGS];

   initial
   begin
      for (int i = 0; i < CPURF_NUM_REGS; i++)
      begin
         mem[i] = CPURF_GPR_INIT[DW-1:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (we && w_idx != CPURF_ZERO_IDX)
      begin
         mem[w_idx] <= w_data;
      end
   end

   // async read ports; zero index forced low
   always_comb
   begin
      ra_data = (ra_idx == CPURF_ZERO_IDX) ? '0 : mem[ra_idx];
      rb_data = (rb_idx == CPURF_ZERO_IDX) ? '0 : mem[rb_idx];
   end
endmodule // cpurf_gpr_array

//--- tb/cpurf_pipe_model.sv
// partner model: pipeline fetch side that steps the program counter
module cpurf_pipe_model
#(
   parameter logic [31:0] START = 32'h0000_2000
)(
   input  wire logic        core_clk,
   input  wire logic        run,
   output logic             pc_load,
   output logic [31:0]      pc_load_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // sequential fetch
   // ********
   // changes just after the edge, so the core always samples a settled address
   assign pc_load = run;
   initial pc_load_addr = START;
   always @(posedge core_clk)
      if (run)
         pc_load_addr <= pc_load_addr + 32'h0000_0004;
endmodule // cpurf_pipe_model

//--- tb/testbench.sv
// self-checking bench for the cpu register file core
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import cpurf_pkg::*;
   localparam logic [63:0] BASE = 64'h0000_0000_0000_2000;
   typedef struct {int due; int kind; logic [31:0] val;} cpurf_note_t;
   logic              core_clk = 1'b0;
   logic              nrst = 1'b0;
   logic              dbg_rst = 1'b0;
   logic              run = 1'b0;
   logic [4:0]        ra_idx = 5'h00;
   logic [4:0]        rb_idx = 5'h00;
   cpurf_wr_t         wr = '0;
   cpurf_sreq_t       sreq = '0;
   logic [2:0]        take = 3'h0;
   logic              exc_in_delay = 1'b0;
   logic [31:0]       ret_addr = 32'h0;
   logic [31:0]       btr_addr = 32'h0;
   logic              carry_wr = 1'b0;
   logic              carry_in = 1'b0;
   logic              pc_load;
   logic [31:0]       pc_load_addr, ra_data_reg, rb_data_reg, mfs_data_reg;
   logic [31:0]       pc_reg, msr_reg, exc_btr_reg;
   logic              carry_reg;
   logic [31:0]       gm [32] = '{default: 32'h0};
   logic [31:0]       seed = 32'h8F7B;
   int                cyc = 0;
   int                mismatches = 0;
   int                checks_done = 0;
   cpurf_note_t       notes [$];
   cpurf_note_t       n;

   cpurf_pipe_model #(.START(BASE[31:0])) cpurf_pipe_model_i (.core_clk(core_clk),
      .run(run), .pc_load(pc_load), .pc_load_addr(pc_load_addr));
   cpurf_core #(.DATA_SIZE(32), .ADDR_SIZE(32), .USE_HW_EXC(1'b1), .BASE_VECTORS(BASE))
      cpurf_core_i (.core_clk(core_clk), .nrst(nrst), .dbg_rst(dbg_rst),
      .ra_idx(ra_idx), .rb_idx(rb_idx), .ra_data_reg(ra_data_reg),
      .rb_data_reg(rb_data_reg), .wr(wr), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
      .irq_take(take[0]), .brk_take(take[1]), .exc_take(take[2]),
      .exc_in_delay(exc_in_delay), .ret_addr(ret_addr), .btr_addr(btr_addr),
      .sreq(sreq), .carry_wr(carry_wr), .carry_in(carry_in),
      .mfs_data_reg(mfs_data_reg), .pc_reg(pc_reg), .msr_reg(msr_reg),
      .carry_reg(carry_reg), .exc_btr_reg(exc_btr_reg));

   // ********
   // helpers
   // ********
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic conclude();
      // a note never reached means an output was never looked at
      mismatches += notes.size();
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(logic got, logic exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t carry %b expected %b", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(negedge core_clk);
   endtask
   task automatic note(int d, int k, logic [31:0] v);
      notes.push_back('{cyc + d, k, v});
   endtask
   task automatic gpr_wr(logic [4:0] i, logic [31:0] d);
      wr = '{1'b1, i, {32'h0, d}};
      gm[i] = (i == 5'h00) ? 32'h0 : d;
      tick();
   endtask
   task automatic rd(logic [4:0] a, logic [4:0] b);
      ra_idx = a;
      rb_idx = b;
      note(1, 0, gm[a]);
      note(1, 1, gm[b]);
      tick();
   endtask
   task automatic rd_all();
      for (int i = 0; i < 32; i++)
         rd(5'(i), 5'(31 - i));
   endtask
   task automatic mfs(logic [13:0] s, logic [31:0] exp);
      sreq.spec = s;
      note(1, 2, exp);
      tick();
   endtask
   task automatic sop(cpurf_sop_t op, logic [13:0] s, logic [31:0] d);
      sreq = '{op, s, {32'h0, d}};
      tick();
      sreq.op = CPURF_SOP_NONE;
   endtask

   initial forever #20 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   initial
   begin
      #100000;
      mismatches++;
      conclude();
   end
   // carry bit of msr_reg may or may not mirror carry, so it is masked
   always @(negedge core_clk)
      while (notes.size() > 0 && notes[0].due == cyc)
      begin
         n = notes.pop_front();
         case (n.kind)
            0: cmp_word(ra_data_reg, n.val);
            1: cmp_word(rb_data_reg, n.val);
            2: cmp_word(mfs_data_reg, n.val);
            3: cmp_word(msr_reg & 32'hFFFF_FFFB, n.val & 32'h7FFF_FFFB);
            5: cmp_word(exc_btr_reg, n.val);
            default: cmp_bit(carry_reg, n.val[0]);
         endcase
      end

   // ********
   // stimulus
   // ********
   initial
   begin
      logic [31:0] d, m;
      logic [4:0]  k;
      logic        car;
      repeat (4) tick();
      nrst = 1'b1;
      mfs(CPURF_SPEC_PC, BASE[31:0]);
      rd_all();
      for (int i = 0; i < 32; i++)
         gpr_wr(5'(i), rnd());
      // write strobe held across back-to-back writes, dropped once
      wr.en = 1'b0;
      rd_all();
      run = 1'b1;
      repeat (6) tick();
      run = 1'b0;
      tick();
      d = pc_load_addr - 32'h4;
      mfs(CPURF_SPEC_PC, d);
      sop(CPURF_SOP_MTS, CPURF_SPEC_PC, rnd());
      mfs(CPURF_SPEC_PC, d);
      nrst = 1'b0;
      repeat (2) tick();
      nrst = 1'b1;
      dbg_rst = 1'b1;
      tick();
      dbg_rst = 1'b0;
      mfs(CPURF_SPEC_PC, BASE[31:0]);
      rd_all();
      for (int c = 0; c < 4; c++)
      begin
         d = rnd();
         ret_addr = d;
         btr_addr = ~d;
         exc_in_delay = (c == 3);
         take[c > 2 ? 2 : c] = 1'b1;
         k = (c == 0) ? CPURF_IRQ_RET_IDX : (c == 1) ? CPURF_BRK_RET_IDX : CPURF_EXC_RET_IDX;
         gm[k] = (c == 3) ? ~d : d;
         note(1, 5, (c == 3) ? ~d : 32'h0);
         tick();
         take = 3'h0;
         rd(k, k);
      end
      // carry forced high so its late landing is visible
      d = rnd() | 32'h8000_0004;
      note(1, 3, d);
      note(1, 4, 32'h0);
      note(2, 4, {31'h0, d[2]});
      sop(CPURF_SOP_MTS, CPURF_SPEC_MSR, d);
      car = d[2];
      m = d & 32'h7FFF_FFFF;
      tick();
      mfs(CPURF_SPEC_MSR, {car, m[30:3], car, m[1:0]});
      note(1, 3, m);
      note(1, 2, 32'h0);
      sop(CPURF_SOP_MTS, 14'h0005, rnd());
      for (int s = 0; s < 2; s++)
      begin
         d = (rnd() & 32'h7FFF_FFFF) | 32'h4;
         m = s ? (m & ~d) : (m | d);
         car = !s;
         // opposing alu carry in the same cycle must lose
         carry_wr = 1'b1;
         carry_in = 1'(s);
         note(1, 3, m);
         note(1, 4, {31'h0, car});
         sop(s ? CPURF_SOP_CLR : CPURF_SOP_SET, 14'h0000, d);
         carry_wr = 1'b0;
         mfs(CPURF_SPEC_MSR, {car, m[30:3], car, m[1:0]});
      end
      carry_wr = 1'b1;
      carry_in = 1'b1;
      note(1, 4, 32'h1);
      tick();
      carry_wr = 1'b0;
      repeat (3) tick();
      conclude();
   end
endmodule // testbench
